/* File: hw/eis_pkg.sv */
package eis_pkg;
   localparam int unsigned CODE_W            = 6;
   localparam int unsigned NUM_SOURCES       = 64;
   localparam int unsigned PORT_W            = 8;
   localparam int unsigned CODE_LSB_PIN      = 2;
   localparam logic [1:0]  LOW_PINS_VALUE    = 2'h0;
   localparam int unsigned ADDR_W            = 16;
   localparam logic [15:0] EXT_VECTOR_ADDR   = 16'h0080;
   localparam logic [15:0] BRANCH_TABLE_BASE = 16'h0100;
   localparam logic [7:0]  PORT_LATCH_RESET  = 8'h00;
   localparam int unsigned CLK_PERIOD_NS     = 20;
   localparam int unsigned COMPANION_REQ_NS  = 100;
   localparam int unsigned CPU_RESPONSE_NS   = 200;
   localparam int unsigned COMPANION_REQ_CYC =
      (COMPANION_REQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CPU_RESPONSE_CYC  =
      (CPU_RESPONSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LAT_W             = 8;

   typedef enum logic [2:0] {
      EIS_IDLE,
      EIS_RAISE,
      EIS_RESPOND,
      EIS_CLEAR,
      EIS_READ,
      EIS_SERVICE
   } eis_state_t;
endpackage

/* File: hw/eis_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface eis_link_if;
   logic       ext_req_n;
   logic [7:0] port_pins;

   modport encoder (
      output ext_req_n,
      output port_pins
   );
   modport processor (
      input  ext_req_n,
      input  port_pins
   );
endinterface
`default_nettype wire

/* File: hw/eis_encoder.sv */
`timescale 1ns/1ps
`default_nettype none
module eis_encoder
   import eis_pkg::*;
#(
   parameter int unsigned N = NUM_SOURCES
) (
   input  wire logic         ref_clk,
   input  wire logic         resetn,
   input  wire logic [N-1:0] dev_req_n,
   eis_link_if.encoder       link
);
   logic                req_n_reg;
   logic [CODE_W-1:0]   code_reg;
   logic [CODE_W-1:0]   code_next;
   logic                any_req;
   logic [N-1:0]        req;

   // Active low requests inverted per source
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_inv
         assign req[g] = ~dev_req_n[g];
      end
   endgenerate

   assign any_req = |req;

   // Lowest device number wins
   always_comb begin
      code_next = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            code_next = CODE_W'(i); // RULE_07 RULE_01 RULE_04
         end
      end
   end

   // AND of all active low lines
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         req_n_reg <= 1'b1;
      end else begin
         req_n_reg <= &dev_req_n; // RULE_09
      end
   end

   // Code frozen while the combined request stands and a source still requests, so a late higher source cannot tear the read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         code_reg <= '0;
      end else if (req_n_reg || !any_req) begin
         code_reg <= code_next; // RULE_11
      end
   end

   assign link.ext_req_n = req_n_reg;
   assign link.port_pins = {code_reg, LOW_PINS_VALUE}; // RULE_02
endmodule
`default_nettype wire

/* File: hw/eis_processor.sv */
// How it works
// RULE_01: Source code is binary, bit0 first.
// RULE_02: Pins 0-1 zero, code on 2-7.
// RULE_03: Port byte equals four times device number.
// RULE_04: Six bits identify up to 64 devices.
// RULE_05: Acknowledge always vectors to fixed external address.
// RULE_06: Latency is companion delay plus CPU response.
// RULE_07: Priority encoder picks highest-priority requester.
// RULE_08: Port read ORs pins with latch; clear first.
// RULE_09: Active-low requests ANDed into one request.
// RULE_10: Timer interrupt off, external interrupt on.
// RULE_11: Code held stable while request asserted.
`timescale 1ns/1ps
`default_nettype none
module eis_processor
   import eis_pkg::*;
#(
   parameter int unsigned REQ_CYC  = COMPANION_REQ_CYC,
   parameter int unsigned RESP_CYC = CPU_RESPONSE_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              resetn,
   eis_link_if.processor          link,
   input  wire logic              port_wr,
   input  wire logic [PORT_W-1:0] port_wdata,
   input  wire logic              service_done,
   output logic                   irq_ack,
   output logic [ADDR_W-1:0]      pc_out,
   output logic [CODE_W-1:0]      device_number,
   output logic [PORT_W-1:0]      port_value,
   output logic                   id_valid,
   output logic                   busy
);
   // Fixed arrangement: timer interrupt off, external interrupt on
   localparam logic TIMER_IRQ_EN = 1'b0; // RULE_10
   localparam logic EXT_IRQ_EN   = 1'b1; // RULE_10

   // Registered outputs, one concern each
   eis_state_t          state_reg;
   logic [LAT_W-1:0]    lat_reg;
   logic [PORT_W-1:0]   latch_reg;
   logic                irq_ack_reg;
   logic [ADDR_W-1:0]   pc_reg;
   logic [CODE_W-1:0]   dev_reg;
   logic [PORT_W-1:0]   port_reg;
   logic                id_valid_reg;
   logic                busy_reg;
   logic [PORT_W-1:0]   port_read;
   logic                ext_pending;
   logic                lat_done;
   logic                ack_now;
   logic                read_now;

   // Reads see the latch too, hence the clear before sampling
   assign port_read   = link.port_pins | latch_reg; // RULE_08
   // Timer path never arms in this arrangement
   assign ext_pending = !link.ext_req_n && EXT_IRQ_EN && !TIMER_IRQ_EN;
   // Decodes shared by several registers
   assign lat_done    = (lat_reg == '0);
   assign ack_now     = (state_reg == EIS_RESPOND) && lat_done;
   assign read_now    = (state_reg == EIS_READ);

   // State register
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= EIS_IDLE;
      end else begin
         unique case (state_reg)
            EIS_IDLE: begin
               if (ext_pending) begin
                  state_reg <= EIS_RAISE;
               end
            end
            EIS_RAISE: begin
               if (lat_done) begin
                  state_reg <= EIS_RESPOND;
               end
            end
            EIS_RESPOND: begin
               if (lat_done) begin
                  state_reg <= EIS_CLEAR;
               end
            end
            EIS_CLEAR: begin
               state_reg <= EIS_READ;
            end
            EIS_READ: begin
               state_reg <= EIS_SERVICE;
            end
            EIS_SERVICE: begin
               // No nesting: requests ignored until service completes
               if (service_done) begin
                  state_reg <= EIS_IDLE;
               end
            end
         endcase
      end
   end

   // Latency counter, reloaded while idle so each request starts fresh
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         lat_reg <= '0;
      end else begin
         unique case (state_reg)
            EIS_IDLE: begin
               lat_reg <= LAT_W'(REQ_CYC - 1);
            end
            EIS_RAISE: begin
               if (lat_done) begin
                  lat_reg <= LAT_W'(RESP_CYC - 1); // RULE_06
               end else begin
                  lat_reg <= lat_reg - 1'b1; // RULE_06
               end
            end
            EIS_RESPOND: begin
               if (!lat_done) begin
                  lat_reg <= lat_reg - 1'b1; // RULE_06
               end
            end
            EIS_CLEAR, EIS_READ, EIS_SERVICE: begin
               lat_reg <= lat_reg;
            end
         endcase
      end
   end

   // Port output latch; the handler zeroes it before the read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         latch_reg <= PORT_LATCH_RESET;
      end else if (state_reg == EIS_CLEAR) begin
         latch_reg <= PORT_LATCH_RESET; // RULE_08
      end else if (port_wr) begin
         latch_reg <= port_wdata;
      end
   end

   // One-cycle acknowledge pulse
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_ack_reg <= 1'b0;
      end else begin
         irq_ack_reg <= ack_now;
      end
   end

   // Vector on acknowledge, table entry after the read
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pc_reg <= '0;
      end else if (ack_now) begin
         pc_reg <= EXT_VECTOR_ADDR; // RULE_05
      end else if (read_now) begin
         // Four-byte table entries line up with the port step of four
         pc_reg <= BRANCH_TABLE_BASE + ADDR_W'(port_read); // RULE_03
      end
   end

   // Byte as read, latch included
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         port_reg <= '0;
      end else if (read_now) begin
         port_reg <= port_read; // RULE_03
      end
   end

   // Device number is the byte without its two zero pins
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         dev_reg <= '0;
      end else if (read_now) begin
         dev_reg <= port_read[PORT_W-1:CODE_LSB_PIN]; // RULE_03 RULE_04
      end
   end

   // Identity valid from the read until back in idle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         id_valid_reg <= 1'b0;
      end else if (read_now) begin
         id_valid_reg <= 1'b1;
      end else if (state_reg == EIS_IDLE) begin
         id_valid_reg <= 1'b0;
      end
   end

   // Tracks the state leaving and re-entering idle, kept in its own flop
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
      end else if ((state_reg == EIS_IDLE) && ext_pending) begin
         busy_reg <= 1'b1;
      end else if ((state_reg == EIS_SERVICE) && service_done) begin
         busy_reg <= 1'b0;
      end
   end

   assign irq_ack       = irq_ack_reg;
   assign pc_out        = pc_reg;
   assign device_number = dev_reg;
   assign port_value    = port_reg;
   assign id_valid      = id_valid_reg;
   assign busy          = busy_reg;
endmodule
`default_nettype wire

/* File: sim/eis_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module eis_assertions
   import eis_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [63:0] dev_req_n,
   input wire logic        ext_req_n,
   input wire logic [7:0]  port_pins
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // Code lines may only change once the combined request is idle or every source has released
   sequence s_idle_req(int k);
      ext_req_n && (dev_req_n == ~(64'h1 << k));
   endsequence
   property p_low_pins;
      port_pins[1:0] == LOW_PINS_VALUE;
   endproperty
   a_low_pins: assert property (p_low_pins) else $error("low port pins not zero");
   property p_and;
      1 |=> ext_req_n == &$past(dev_req_n);
   endproperty
   a_and: assert property (p_and) else $error("combined request wrong");
   property p_rise;
      $rose(ext_req_n) |-> $past(&dev_req_n);
   endproperty
   a_rise: assert property (p_rise) else $error("request released early");
   property p_hold;
      (!ext_req_n && !(&dev_req_n)) |=> $stable(port_pins[7:2]);
   endproperty
   a_hold: assert property (p_hold) else $error("code moved while requested");
   property p_dev0;
      (ext_req_n && !dev_req_n[0]) |=> port_pins == 8'h00;
   endproperty
   a_dev0: assert property (p_dev0) else $error("device zero code wrong");
   property p_dev1;
      s_idle_req(1) |=> port_pins == 8'h04;
   endproperty
   a_dev1: assert property (p_dev1) else $error("device one code wrong");
   property p_dev5;
      s_idle_req(5) |=> port_pins == 8'h14;
   endproperty
   a_dev5: assert property (p_dev5) else $error("device five code wrong");
   property p_dev63;
      s_idle_req(63) |=> port_pins == 8'hfc;
   endproperty
   a_dev63: assert property (p_dev63) else $error("device 63 code wrong");
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eis_pkg::*;
   logic        ref_clk, resetn, port_wr, service_done, irq_ack, id_valid, busy;
   logic [63:0] dev_req_n;
   logic [7:0]  port_wdata, port_value;
   logic [15:0] pc_out;
   logic [5:0]  device_number;
   int          n_mismatch = 0, checked = 0, cyc = 0;
   eis_link_if link ();
   eis_encoder eis_encoder_i (.ref_clk(ref_clk), .resetn(resetn), .dev_req_n(dev_req_n), .link(link));
   // Short counts keep each service to a few cycles
   eis_processor #(.REQ_CYC(1), .RESP_CYC(1)) eis_processor_i (.ref_clk(ref_clk), .resetn(resetn),
      .link(link), .port_wr(port_wr), .port_wdata(port_wdata), .service_done(service_done),
      .irq_ack(irq_ack), .pc_out(pc_out), .device_number(device_number), .port_value(port_value),
      .id_valid(id_valid), .busy(busy));
   eis_assertions eis_assertions_i (.ref_clk(ref_clk), .resetn(resetn), .dev_req_n(dev_req_n),
      .ext_req_n(link.ext_req_n), .port_pins(link.port_pins));
   task automatic give_verdict();
      $display("checked %0d, n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Latch is dirtied first, so a missing clear shows in the low bits
   task automatic serve(input logic [63:0] req, input logic [5:0] dev);
      int n;
      n = 0;
      @(posedge ref_clk);
      #1 dev_req_n = req;
      port_wr = 1'b1;
      do begin
         @(posedge ref_clk);
         #1 port_wr = 1'b0;
         n++;
      end while (irq_ack !== 1'b1 && n < 50);
      cmp(16'(n), 16'd4);
      cmp(pc_out, EXT_VECTOR_ADDR);
      repeat (2) @(posedge ref_clk);
      #1 cmp({8'h00, port_value}, {8'h00, dev, 2'h0});
      cmp({10'h000, device_number}, {10'h000, dev});
      cmp(pc_out, BRANCH_TABLE_BASE + {8'h00, dev, 2'h0});
      cmp({15'h0000, id_valid}, 16'h0001);
      dev_req_n = '1;
      service_done = 1'b1;
      @(posedge ref_clk);
      #1 service_done = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 cmp({14'h0000, busy, id_valid}, 16'h0000);
      $display("test done for device %0d", dev);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      resetn = 1'b0;
      dev_req_n = '1;
      port_wr = 1'b0;
      port_wdata = 8'h03;
      service_done = 1'b0;
      repeat (16) @(posedge ref_clk);
      #1 resetn = 1'b1;
      serve(~64'h1, 6'h00);
      serve(~64'h2, 6'h01);
      serve(~64'h10, 6'h04);
      serve(~64'h20, 6'h05);
      serve(~64'h220, 6'h05);
      serve(~64'h1000_0000_0000_000c, 6'h02);
      serve(~(64'h1 << 63), 6'h3f);
      give_verdict();
   end
endmodule
`default_nettype wire
